// [rtl/scci_regs.vh]
`ifndef SCCI_REGS_VH
`define SCCI_REGS_VH
// command codes {cs_n, ras_n, cas_n, we_n}
`define SCCI_CMD_MRS 4'h0
`define SCCI_CMD_REF 4'h1
`define SCCI_CMD_PRE 4'h2
`define SCCI_CMD_ACT 4'h3
`define SCCI_CMD_WR 4'h4
`define SCCI_CMD_RD 4'h5
`define SCCI_CMD_ZQC 4'h6
`define SCCI_CMD_NOP 4'h7
// address field positions
`define SCCI_AP_BIT 10
`define SCCI_BC_BIT 12
`define SCCI_TDQS_BIT 11
// mode register selected by bank address for the tdqs option
`define SCCI_MR1_SEL 3'h1
// reset values
`define SCCI_BANK_OPEN_RST 8'h00
`define SCCI_TDQS_RST 1'b0
`endif

// [rtl/scci_dm_mask.v]
`timescale 1ns/1ps
// ----------------------------------------
// write data mask, one beat per rising clock edge
// ----------------------------------------
module scci_dm_mask #(
    parameter DW = 8
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_wr_active,
    input wire i_beat_valid,
    input wire [DW-1:0] i_beat_data,
    input wire i_dm,
    input wire i_tdqs_en,
    output reg o_wr_valid,
    output reg [DW-1:0] o_wr_data,
    output reg o_tdqs
);
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr_valid <= 1'b0;
            o_wr_data <= {DW{1'b0}};
            o_tdqs <= 1'b0;
        end else begin
            o_wr_valid <= i_wr_active & i_beat_valid & (i_tdqs_en | ~i_dm);
            if (i_beat_valid) begin
                o_wr_data <= i_beat_data;
            end
            o_tdqs <= i_tdqs_en & i_dm;
        end
    end
endmodule // scci_dm_mask

// [rtl/scci_top.v]
// Behaviour
// - capture inputs on clock rising crossing
// - cke high runs clocks and buffers
// - cke low idle: precharge powerdown or selfrefresh
// - cke low with open row: active powerdown
// - selfrefresh exit on cke high, taken at the next rising clock edge
// - powerdown keeps clock, odt, cke; dm still drives o_tdqs and beats still load o_wr_data
// - selfrefresh keeps clock and cke; dm still drives o_tdqs and beats still load o_wr_data
// - chip select high masks command
// - command from cs, ras, cas, we
// - masked write beats are discarded unless mr1 a11 has selected tdqs, then they pass
// - data mask sampled every rising clock edge
// - mr1 a11 selects mask or tdqs
// - bank address picks bank or register
// - a10 auto-precharge or all-bank precharge
// - a12 selects burst chop on fly
`timescale 1ns/1ps
`include "scci_regs.vh"
module scci_top #(
    parameter AW = 16,
    parameter DW = 8
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_cke,
    input wire i_cs_n,
    input wire i_ras_n,
    input wire i_cas_n,
    input wire i_we_n,
    input wire [2:0] i_ba,
    input wire [AW-1:0] i_addr,
    input wire i_odt,
    input wire i_beat_valid,
    input wire [DW-1:0] i_beat_data,
    input wire i_dm,
    output reg [3:0] o_cmd,
    output reg o_cmd_valid,
    output reg [2:0] o_bank,
    output reg o_auto_pre,
    output reg o_pre_all,
    output reg o_burst_chop,
    output reg [7:0] o_bank_open,
    output reg o_clk_run,
    output reg o_odt,
    output reg [3:0] o_state,
    output reg o_tdqs_en,
    output wire o_wr_valid,
    output wire [DW-1:0] o_wr_data,
    output wire o_tdqs
);
    localparam ST_ACT = 4'h1;
    localparam ST_PPD = 4'h2;
    localparam ST_APD = 4'h4;
    localparam ST_SR = 4'h8;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_s1_q;
    reg rst_q;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // self-refresh exit
    // ----------------------------------------
    // cke level alone
    // sr exit is taken from the cke level combinationally, but the state leaves self-refresh
    // only on the next rising clock edge, when the registered state loads state_d
    wire sr_exit = (o_state == ST_SR) & i_cke;

    function [3:0] code_of;
        input cs_n;
        input ras_n;
        input cas_n;
        input we_n;
        begin
            code_of = {cs_n, ras_n, cas_n, we_n};
        end
    endfunction

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    reg [3:0] state_d;
    reg [7:0] open_d;
    reg [3:0] cmd_d;
    reg valid_d;
    reg tdqs_d;
    reg run_d;
    reg [3:0] code;
    always @* begin
        code = code_of(i_cs_n, i_ras_n, i_cas_n, i_we_n);
        state_d = o_state;
        open_d = o_bank_open;
        cmd_d = `SCCI_CMD_NOP;
        valid_d = 1'b0;
        tdqs_d = o_tdqs_en;
        case (o_state)
            ST_ACT: begin
                if (!i_cs_n) begin
                    cmd_d = code;
                    valid_d = (code != `SCCI_CMD_NOP);
                end
                if (!i_cke) begin
                    // a command on the power-down entry edge is not executed, so no pulse
                    valid_d = 1'b0;
                    if (o_bank_open != 8'h00) begin
                        state_d = ST_APD;
                    end else if (!i_cs_n && code == `SCCI_CMD_REF) begin
                        state_d = ST_SR;
                        valid_d = 1'b0;
                    end else begin
                        state_d = ST_PPD;
                    end
                end else begin
                    if (valid_d) begin
                        case (code)
                            `SCCI_CMD_ACT: begin
                                open_d = o_bank_open | (8'h01 << i_ba);
                            end
                            `SCCI_CMD_PRE: begin
                                if (i_addr[`SCCI_AP_BIT]) begin
                                    open_d = 8'h00;
                                end else begin
                                    open_d = o_bank_open & ~(8'h01 << i_ba);
                                end
                            end
                            `SCCI_CMD_RD, `SCCI_CMD_WR: begin
                                if (i_addr[`SCCI_AP_BIT]) begin
                                    open_d = o_bank_open & ~(8'h01 << i_ba);
                                end
                            end
                            `SCCI_CMD_MRS: begin
                                if (i_ba == `SCCI_MR1_SEL) begin
                                    tdqs_d = i_addr[`SCCI_TDQS_BIT];
                                end
                            end
                            default: begin
                                open_d = o_bank_open;
                            end
                        endcase
                    end else begin
                        valid_d = 1'b0;
                    end
                end
            end
            ST_PPD, ST_APD: begin
                if (i_cke) begin
                    state_d = ST_ACT;
                end
            end
            ST_SR: begin
                if (sr_exit) begin
                    state_d = ST_ACT;
                end
            end
            default: begin
                state_d = ST_ACT;
            end
        endcase
        run_d = (state_d == ST_ACT);
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // rising crossing capture
    always @(posedge i_ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            o_state <= ST_ACT;
            o_bank_open <= `SCCI_BANK_OPEN_RST;
            o_cmd <= `SCCI_CMD_NOP;
            o_cmd_valid <= 1'b0;
            o_bank <= 3'h0;
            o_auto_pre <= 1'b0;
            o_pre_all <= 1'b0;
            o_burst_chop <= 1'b0;
            o_clk_run <= 1'b1;
            o_odt <= 1'b0;
            o_tdqs_en <= `SCCI_TDQS_RST;
        end else begin
            o_state <= state_d;
            o_bank_open <= open_d;
            o_cmd <= cmd_d;
            o_cmd_valid <= valid_d;
            o_tdqs_en <= tdqs_d;
            o_clk_run <= run_d;
            // odt stays live in power-down but not in self-refresh
            if (o_state != ST_SR) begin
                o_odt <= i_odt;
            end
            if (valid_d) begin
                o_bank <= i_ba;
                o_auto_pre <= i_addr[`SCCI_AP_BIT];
                o_pre_all <= (cmd_d == `SCCI_CMD_PRE) & i_addr[`SCCI_AP_BIT];
                o_burst_chop <= ((cmd_d == `SCCI_CMD_RD) | (cmd_d == `SCCI_CMD_WR)) &
                    ~i_addr[`SCCI_BC_BIT];
            end
        end
    end

    scci_dm_mask #(
        .DW(DW)
    ) u_dm (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_q),
        .i_wr_active(o_clk_run),
        .i_beat_valid(i_beat_valid),
        .i_beat_data(i_beat_data),
        .i_dm(i_dm),
        .i_tdqs_en(o_tdqs_en),
        .o_wr_valid(o_wr_valid),
        .o_wr_data(o_wr_data),
        .o_tdqs(o_tdqs)
    );
endmodule // scci_top

// [bench/scci_checker.sv]
`timescale 1ns/1ps
`include "scci_regs.vh"
module scci_checker #(
    parameter AW = 16,
    parameter DW = 8
) (
    input logic i_ref_clk,
    input logic i_rst_n,
    input logic i_cke,
    input logic i_cs_n,
    input logic i_ras_n,
    input logic i_cas_n,
    input logic i_we_n,
    input logic i_beat_valid,
    input logic [DW-1:0] i_beat_data,
    input logic i_dm,
    input logic [3:0] o_cmd,
    input logic o_cmd_valid,
    input logic [2:0] o_bank,
    input logic [7:0] o_bank_open,
    input logic o_clk_run,
    input logic [3:0] o_state,
    input logic o_tdqs_en,
    input logic o_wr_valid,
    input logic [DW-1:0] o_wr_data
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire [3:0] cmd_w = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    a_cs_masks: assert property (i_cs_n |=> !o_cmd_valid)
        else $error("command passed with chip select high");
    a_cmd_code: assert property (o_cmd_valid |-> o_cmd == $past(cmd_w))
        else $error("command code differs from sampled pins");
    a_cmd_taken: assert property (o_state == 4'h1 && i_cke && cmd_w < 4'h7 |=> o_cmd_valid)
        else $error("command not taken in active state");
    a_act_opens: assert property (o_cmd_valid && o_cmd == `SCCI_CMD_ACT |-> o_bank_open[o_bank])
        else $error("activated bank not open");
    a_pd_ignores: assert property (o_state != 4'h1 |=> !o_cmd_valid)
        else $error("command taken while powered down");
    a_apd_entry: assert property (
        o_state == 4'h1 && !i_cke && i_cs_n && |o_bank_open |=> o_state == 4'h4)
        else $error("open bank did not give active power-down");
    a_idle_entry: assert property (
        o_state == 4'h1 && !i_cke && o_bank_open == 8'h00
        && (i_cs_n || cmd_w == `SCCI_CMD_REF) |=> o_state == ($past(i_cs_n) ? 4'h2 : 4'h8))
        else $error("idle entry state wrong");
    a_sr_exit: assert property (o_state == 4'h8 && i_cke |=> o_state == 4'h1)
        else $error("self-refresh exit missed");
    a_clk_gate: assert property (o_clk_run == (o_state == 4'h1))
        else $error("clock run flag disagrees with state");
    a_dm_drop: assert property (i_beat_valid && i_dm && !o_tdqs_en |=> !o_wr_valid)
        else $error("masked beat accepted");
    a_beat_pass: assert property (
        i_beat_valid && !i_dm && o_clk_run |=> o_wr_valid && o_wr_data == $past(i_beat_data))
        else $error("unmasked beat lost or altered");
endmodule // scci_checker

// [bench/scci_ctl_model.sv]
`timescale 1ns/1ps
module scci_ctl_model (
    input wire logic i_clk,
    output logic o_cke,
    output logic [3:0] o_code,
    output logic [2:0] o_ba,
    output logic [15:0] o_addr
);
    initial begin
        o_cke = 1'b1;
        o_code = 4'hF;
        o_ba = 3'h0;
        o_addr = 16'h0000;
    end
    // valid at one edge, deselect after, cke held
    task issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a, input logic k);
        @(posedge i_clk);
        o_code <= c;
        o_ba <= b;
        o_addr <= a;
        o_cke <= k;
        @(posedge i_clk);
        o_code <= 4'hF;
        o_ba <= ~b;
        o_addr <= ~a;
        #1;
    endtask
endmodule // scci_ctl_model

// [bench/tb.sv]
`timescale 1ns/1ps
`include "scci_regs.vh"
module tb;
    logic clk = 1'b0, rst_n = 1'b0, bv = 1'b0, dm = 1'b0, od = 1'b0;
    logic [7:0] bd = 8'h00;
    wire cke, cv, ap, pa, bc, cr, odt, te, wv, tq;
    wire [3:0] code, cmd, st;
    wire [2:0] ba, bank;
    wire [15:0] addr;
    wire [7:0] bo, wd;
    int n_mismatch = 0, comparisons = 0;
    always #10 clk = ~clk;
    scci_ctl_model scci_ctl_model_i (.i_clk(clk), .o_cke(cke), .o_code(code), .o_ba(ba),
        .o_addr(addr));
    scci_top scci_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cke(cke), .i_cs_n(code[3]),
        .i_ras_n(code[2]), .i_cas_n(code[1]), .i_we_n(code[0]), .i_ba(ba), .i_addr(addr),
        .i_odt(od), .i_beat_valid(bv), .i_beat_data(bd), .i_dm(dm), .o_cmd(cmd),
        .o_cmd_valid(cv), .o_bank(bank), .o_auto_pre(ap), .o_pre_all(pa), .o_burst_chop(bc),
        .o_bank_open(bo), .o_clk_run(cr), .o_odt(odt), .o_state(st), .o_tdqs_en(te),
        .o_wr_valid(wv), .o_wr_data(wd), .o_tdqs(tq));
    task chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task beat(input logic m, input logic [7:0] d);
        @(posedge clk);
        bv <= 1'b1;
        dm <= m;
        bd <= d;
        @(posedge clk);
        bv <= 1'b0;
        dm <= 1'b0;
        bd <= ~d;
        #1;
    endtask
    task t_act_mask;
        scci_ctl_model_i.issue(`SCCI_CMD_ACT, 3'h2, 16'h0000, 1'b1);
        chk(cmd, `SCCI_CMD_ACT);
        chk(cv, 1'b1);
        chk(bank, 3'h2);
        chk(bo, 8'h04);
        scci_ctl_model_i.issue(4'hA, 3'h2, 16'h0400, 1'b1);
        chk(cv, 1'b0);
        chk(bo, 8'h04);
    endtask
    task t_apd;
        scci_ctl_model_i.issue(4'hF, 3'h0, 16'h0000, 1'b0);
        chk(st, 4'h4);
        chk(cr, 1'b0);
        @(posedge clk);
        od <= 1'b1;
        @(posedge clk);
        #1;
        chk(odt, 1'b1);
        scci_ctl_model_i.issue(`SCCI_CMD_ACT, 3'h5, 16'h0000, 1'b0);
        chk(bo, 8'h04);
        scci_ctl_model_i.issue(4'hF, 3'h0, 16'h0000, 1'b1);
        chk(st, 4'h1);
    endtask
    task t_rd_pre;
        scci_ctl_model_i.issue(`SCCI_CMD_RD, 3'h2, 16'h0000, 1'b1);
        chk(bc, 1'b1);
        chk(ap, 1'b0);
        scci_ctl_model_i.issue(`SCCI_CMD_PRE, 3'h0, 16'h0400, 1'b1);
        chk(pa, 1'b1);
        chk(bo, 8'h00);
        scci_ctl_model_i.issue(`SCCI_CMD_ACT, 3'h3, 16'h0000, 1'b1);
        scci_ctl_model_i.issue(`SCCI_CMD_ACT, 3'h6, 16'h0000, 1'b1);
        chk(bo, 8'h48);
        scci_ctl_model_i.issue(`SCCI_CMD_PRE, 3'h6, 16'h0000, 1'b1);
        chk(pa, 1'b0);
        chk(bo, 8'h08);
        scci_ctl_model_i.issue(`SCCI_CMD_WR, 3'h3, 16'h1400, 1'b1);
        chk(ap, 1'b1);
        chk(bc, 1'b0);
        chk(bo, 8'h00);
    endtask
    task t_sleep;
        scci_ctl_model_i.issue(4'hF, 3'h0, 16'h0000, 1'b0);
        chk(st, 4'h2);
        scci_ctl_model_i.issue(4'hF, 3'h0, 16'h0000, 1'b1);
        scci_ctl_model_i.issue(`SCCI_CMD_REF, 3'h0, 16'h0000, 1'b0);
        chk(st, 4'h8);
        @(posedge clk);
        od <= 1'b0;
        @(posedge clk);
        #1;
        chk(odt, 1'b1);
        scci_ctl_model_i.issue(`SCCI_CMD_ACT, 3'h1, 16'h0000, 1'b0);
        chk(bo, 8'h00);
        scci_ctl_model_i.issue(4'hF, 3'h0, 16'h0000, 1'b1);
        chk(st, 4'h1);
        @(posedge clk);
        #1;
        chk(odt, 1'b0);
    endtask
    task t_mask_beats;
        beat(1'b0, 8'h5A);
        chk(wd, 8'h5A);
        beat(1'b1, 8'hC3);
        chk(wv, 1'b0);
        scci_ctl_model_i.issue(`SCCI_CMD_MRS, 3'h1, 16'h0800, 1'b1);
        chk(te, 1'b1);
        beat(1'b1, 8'h3C);
        chk(tq, 1'b1);
    endtask
    initial begin
        #100000;
        n_mismatch++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_act_mask;
        t_apd;
        t_rd_pre;
        t_sleep;
        t_mask_beats;
        summarize;
    end
endmodule // tb
bind scci_top scci_checker #(.AW(AW), .DW(DW)) scci_checker_i (.*);
